// File: include/oxs_pkg.sv
package oxs_pkg;
  // first-byte word selects (low seven bits)
  localparam logic [6:0] SEL_COMMAND = 7'h00;
  localparam logic [6:0] SEL_OXYGEN  = 7'h01;
  localparam logic [6:0] SEL_LAMBDA  = 7'h02;
  // status codes
  localparam logic [7:0] ST_NORMAL   = 8'h00;
  localparam logic [7:0] ST_INIT     = 8'h01;
  localparam logic [7:0] ST_WARM_A   = 8'h41;
  localparam logic [7:0] ST_WARM_B   = 8'h51;
  // command word bit positions
  localparam int BIT_CAL_REQ    = 0;
  localparam int BIT_COMMIT     = 3;
  localparam int BIT_CAL_FAILED = 5;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // values returned while measurements are invalid
  localparam logic [15:0] OXY_INVALID = 16'h8000;
  localparam logic [15:0] LAM_INVALID = 16'h0000;
  localparam logic [15:0] CAL_RESET   = 16'h0000;
  // timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int CAL_TIME_MS    = 2000;
  localparam int CAL_CYCLES     = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam int INIT_TIME_US   = 1000;
  localparam int INIT_CYCLES    = INIT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int COMMIT_TIME_US = 100;
  localparam int COMMIT_CYCLES  = COMMIT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W          = 32;
  typedef enum logic [1:0] {PH_INIT, PH_WARM, PH_RUN} oxs_phase_t;
endpackage

// File: rtl/oxs_spi_slave.sv
// Function
// - after reset run initialization, then heat; normal only after warm-up.
// - status 0x01 while initializing; 0x41 or 0x51 while warming up.
// - status 0x00 once sensor is ready and normal.
// - calibration request bit 0 stays high until calibration ends.
// - error during calibration aborts it and sets failed bit 5.
// - successful calibration completes after about 2 seconds, request clears.
// - any non-zero status during calibration marks it failed.
// - uncommitted calibration used only until next reset; stored one applies.
// - oxygen read: 0x01 then two dummies; reply status, low, high.
// - first byte 0x02 returns lambda in the same frame format.
// - invalid status returns 0x0000 for lambda, 0x8000 for oxygen.
// - values are high*256+low, scaled by 1000; oxygen signed.
// - after calibration, command low byte reads 0x00 or 0x20.
// - command read: 0x00 then dummy; low byte in second reply.
// - reply to first byte of every frame is current status code.
// - first byte top bit selects write; low seven bits select word.
// - mode 0, msb first, sample rising, change falling, clock idles low.
// - storage-commit bit clears itself when the commit completes.
`timescale 1ns/1ps
module oxs_spi_slave #(
  parameter int CAL_CYCLES_P    = oxs_pkg::CAL_CYCLES,
  parameter int INIT_CYCLES_P   = oxs_pkg::INIT_CYCLES,
  parameter int COMMIT_CYCLES_P = oxs_pkg::COMMIT_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic        heater_ready,
  input  wire logic        warm_alt_code,
  input  wire logic [7:0]  fault_code,
  input  wire logic [15:0] oxygen_value,
  input  wire logic [15:0] lambda_value,
  input  wire logic [15:0] stored_cal,
  input  wire logic [15:0] measured_cal,
  input  wire logic        cal_error,
  output logic             heater_on,
  output logic [7:0]       status_code,
  output logic [15:0]      active_cal,
  output logic             commit_strobe,
  output logic [15:0]      commit_data
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage only feeds second
  logic [1:0] cs_s_q, sclk_s_q, mosi_s_q;
  logic       sclk_prev_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_q      <= 2'h3;
      sclk_s_q    <= 2'h0;
      mosi_s_q    <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_s_q      <= {cs_s_q[0], cs_n};
      sclk_s_q    <= {sclk_s_q[0], sclk};
      mosi_s_q    <= {mosi_s_q[0], mosi};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  wire cs_act  = ~cs_s_q[1];
  wire sclk_r  = cs_act & sclk_s_q[1] & ~sclk_prev_q;
  wire sclk_f  = cs_act & ~sclk_s_q[1] & sclk_prev_q;
  wire mosi_in = mosi_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // operating phase
  oxs_pkg::oxs_phase_t phase_q;
  logic [oxs_pkg::CNT_W-1:0] init_cnt_q;
  wire init_done = (init_cnt_q >= oxs_pkg::CNT_W'(INIT_CYCLES_P - 1));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q    <= oxs_pkg::PH_INIT;
      init_cnt_q <= '0;
    end else begin
      unique case (phase_q)
        oxs_pkg::PH_INIT: begin
          init_cnt_q <= init_cnt_q + 1'b1;
          if (init_done) phase_q <= oxs_pkg::PH_WARM;
        end
        oxs_pkg::PH_WARM: if (heater_ready) phase_q <= oxs_pkg::PH_RUN;
        oxs_pkg::PH_RUN: ;
      endcase
    end
  end

  // status selection; a fault code overrides in normal operation
  wire [7:0] warm_code = warm_alt_code ? oxs_pkg::ST_WARM_B : oxs_pkg::ST_WARM_A;
  wire [7:0] status_d  = (phase_q == oxs_pkg::PH_INIT) ? oxs_pkg::ST_INIT :
                         (phase_q == oxs_pkg::PH_WARM) ? warm_code : fault_code;
  // oxygen/lambda marked valid only for normal and the two supply warnings
  wire meas_valid = (phase_q == oxs_pkg::PH_RUN) &&
                    (fault_code == oxs_pkg::ST_NORMAL || fault_code == 8'h31 ||
                     fault_code == 8'h32);

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine
  logic [7:0] rx_q, tx_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] first_q;
  logic       wr_pulse_q;
  logic [7:0] wr_data_q;
  logic [7:0] cmd_q;

  wire [7:0] rx_byte   = {rx_q[6:0], mosi_in};
  wire       byte_end  = sclk_r & (bit_q == 3'h7);
  wire [7:0] first_b   = (byte_q == 2'h0) ? rx_byte : first_q;
  wire [6:0] sel       = first_b[6:0];
  wire [15:0] oxy_word = meas_valid ? oxygen_value : oxs_pkg::OXY_INVALID;
  wire [15:0] lam_word = meas_valid ? lambda_value : oxs_pkg::LAM_INVALID;
  wire [15:0] rd_word  = (sel == oxs_pkg::SEL_OXYGEN) ? oxy_word :
                         (sel == oxs_pkg::SEL_LAMBDA) ? lam_word :
                         (sel == oxs_pkg::SEL_COMMAND) ? {8'h00, cmd_q} : 16'h0000;
  // low byte answers byte 1, high byte answers byte 2
  wire [7:0] next_tx   = (byte_q == 2'h0) ? rd_word[7:0] : rd_word[15:8];
  wire       cmd_write = byte_end & (byte_q == 2'h1) & first_q[7] &
                         (first_q[6:0] == oxs_pkg::SEL_COMMAND);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      bit_q      <= 3'h0;
      byte_q     <= 2'h0;
      first_q    <= 8'h00;
      wr_pulse_q <= 1'b0;
      wr_data_q  <= 8'h00;
      miso       <= 1'b0;
    end else begin
      wr_pulse_q <= cmd_write;
      if (cmd_write) wr_data_q <= rx_byte;
      if (!cs_act) begin
        bit_q  <= 3'h0;
        byte_q <= 2'h0;
        tx_q   <= status_d;
        miso   <= status_d[7];
      end else begin
        if (sclk_r) begin
          rx_q  <= rx_byte;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            if (byte_q == 2'h0) first_q <= rx_byte;
            if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
            tx_q <= next_tx;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        if (sclk_f) miso <= tx_q[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command word, calibration and commit
  logic [oxs_pkg::CNT_W-1:0] cal_cnt_q, com_cnt_q;
  wire cal_busy   = cmd_q[oxs_pkg::BIT_CAL_REQ];
  wire cal_fault  = cal_busy & ((status_d != oxs_pkg::ST_NORMAL) | cal_error);
  wire cal_ok     = cal_busy & ~cal_fault &
                    (cal_cnt_q >= oxs_pkg::CNT_W'(CAL_CYCLES_P - 1));
  wire com_busy   = cmd_q[oxs_pkg::BIT_COMMIT];
  wire com_done   = com_busy & (com_cnt_q >= oxs_pkg::CNT_W'(COMMIT_CYCLES_P - 1));
  // a new start is accepted only when idle; reserved bits never stored
  wire start_cal  = wr_pulse_q & wr_data_q[oxs_pkg::BIT_CAL_REQ] & ~cal_busy & ~com_busy;
  wire start_com  = wr_pulse_q & wr_data_q[oxs_pkg::BIT_COMMIT] & ~cal_busy & ~com_busy;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q         <= oxs_pkg::CMD_RESET;
      cal_cnt_q     <= '0;
      com_cnt_q     <= '0;
      active_cal    <= oxs_pkg::CAL_RESET;
      commit_strobe <= 1'b0;
      commit_data   <= oxs_pkg::CAL_RESET;
      status_code   <= oxs_pkg::ST_INIT;
      heater_on     <= 1'b0;
    end else begin
      status_code   <= status_d;
      heater_on     <= (phase_q != oxs_pkg::PH_INIT);
      commit_strobe <= com_done;
      if (phase_q == oxs_pkg::PH_INIT) active_cal <= stored_cal;
      if (start_cal) begin
        cmd_q[oxs_pkg::BIT_CAL_REQ]    <= 1'b1;
        cmd_q[oxs_pkg::BIT_CAL_FAILED] <= 1'b0;
        cal_cnt_q <= '0;
      end else if (cal_fault) begin
        cmd_q[oxs_pkg::BIT_CAL_REQ]    <= 1'b0;
        cmd_q[oxs_pkg::BIT_CAL_FAILED] <= 1'b1;
      end else if (cal_ok) begin
        cmd_q[oxs_pkg::BIT_CAL_REQ] <= 1'b0;
        active_cal <= measured_cal;
      end else if (cal_busy) begin
        cal_cnt_q <= cal_cnt_q + 1'b1;
      end
      if (start_com) begin
        cmd_q[oxs_pkg::BIT_COMMIT] <= 1'b1;
        com_cnt_q   <= '0;
        commit_data <= active_cal;
      end else if (com_done) begin
        cmd_q[oxs_pkg::BIT_COMMIT] <= 1'b0;
      end else if (com_busy) begin
        com_cnt_q <= com_cnt_q + 1'b1;
      end
    end
  end

endmodule

// File: test/oxs_properties.sv
`timescale 1ns/1ps
module oxs_properties #(
  parameter int INIT_CYCLES_P = 20
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        miso,
  input wire logic        heater_ready,
  input wire logic [7:0]  fault_code,
  input wire logic [15:0] stored_cal,
  input wire logic        heater_on,
  input wire logic [7:0]  status_code,
  input wire logic [15:0] active_cal,
  input wire logic        commit_strobe,
  input wire logic [15:0] commit_data
);
  logic [7:0] cnt_q;
  // saturating count of cycles since reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_run_quiet;
    (heater_on && heater_ready && fault_code == 8'h00) [*3];
  endsequence
  a_init_code: assert property (!heater_on |-> status_code == 8'h01)
    else $error("code not init before heating");
  a_warm_code: assert property (heater_on && $past(heater_on) && !heater_ready
    |-> status_code inside {8'h41, 8'h51}) else $error("bad warm-up code");
  a_init_short: assert property (!heater_on |-> int'(cnt_q) <= INIT_CYCLES_P + 2)
    else $error("heater late");
  a_init_long: assert property (heater_on |-> int'(cnt_q) >= INIT_CYCLES_P - 2)
    else $error("heater early");
  a_normal_code: assert property (s_run_quiet |-> status_code == 8'h00)
    else $error("normal code missing");
  a_commit_pulse: assert property (commit_strobe |=> !commit_strobe)
    else $error("commit strobe too long");
  a_commit_data: assert property (commit_strobe |-> commit_data == active_cal)
    else $error("commit data differs");
  a_reload_cal: assert property (cnt_q == 8'h02 |-> active_cal == stored_cal)
    else $error("stored cal not applied");
  a_miso_hold: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_idle_msb: assert property ((cs_n && $stable(status_code)) [*4]
    |-> miso == status_code[7]) else $error("idle miso not status msb");
endmodule

// File: test/oxs_host_model.sv
`timescale 1ns/1ps
module oxs_host_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // byte gaps shortened to 1 us to keep the run short
  task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    // keep select high long enough for the slave's synchroniser to see the frame end
    #300 cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      if (i % 8 == 0) #1000;
      mosi = tx[23 - i];
      #100 sclk = 1'b1;
      rx[23 - i] = miso;
      #100 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
  logic        core_clk, rstn, cs_n, sclk, mosi, miso, heater_ready, warm_alt_code;
  logic        cal_error, heater_on, commit_strobe;
  logic [7:0]  fault_code, status_code;
  logic [15:0] oxygen_value, lambda_value, stored_cal, measured_cal, active_cal, commit_data;
  logic [23:0] rx;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          commits = 0;
  logic [55:0] rows [6] = '{{8'h00, 24'h010000, 24'h000CFE}, {8'h00, 24'h020000, 24'h00D204},
    {8'h00, 24'h000000, 24'h000000}, {8'h14, 24'h010000, 24'h140080},
    {8'h14, 24'h020000, 24'h140000}, {8'h31, 24'h010000, 24'h310CFE}};
  oxs_spi_slave #(.CAL_CYCLES_P(2000), .INIT_CYCLES_P(20), .COMMIT_CYCLES_P(10)) u_oxs_spi_slave (
    .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .heater_ready(heater_ready), .warm_alt_code(warm_alt_code), .fault_code(fault_code),
    .oxygen_value(oxygen_value), .lambda_value(lambda_value), .stored_cal(stored_cal),
    .measured_cal(measured_cal), .cal_error(cal_error), .heater_on(heater_on),
    .status_code(status_code), .active_cal(active_cal), .commit_strobe(commit_strobe),
    .commit_data(commit_data));
  oxs_host_model u_oxs_host_model (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (commit_strobe === 1'b1) commits++;
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rd(input logic [23:0] tx, input logic [23:0] ex);
    u_oxs_host_model.frame(3, tx, rx);
    `CHK("reply", ex, rx)
    tick(4);
  endtask
  task automatic wr(input logic [7:0] b);
    u_oxs_host_model.frame(2, {8'h80, b, 8'h00}, rx);
    tick(4);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    heater_ready = 1'b0;
    warm_alt_code = 1'b1;
    fault_code = 8'h00;
    oxygen_value = 16'hFE0C;
    lambda_value = 16'h04D2;
    stored_cal = 16'h0BAD;
    measured_cal = 16'h1234;
    cal_error = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(1);
    `CHK("init", 8'h01, status_code)
    tick(30);
    `CHK("heater", 1'b1, heater_on)
    rd(24'h000000, 24'h510000);
    warm_alt_code = 1'b0;
    tick(3);
    `CHK("warm", 8'h41, status_code)
    heater_ready = 1'b1;
    tick(3);
    `CHK("ready", 8'h00, status_code)
    // bounded warm-up poll, scaled down from the host's long timeout
    for (int k = 0; k < 8 && rx[23:16] != 8'h00; k++) u_oxs_host_model.frame(1, 24'h000000, rx);
    `CHK("poll", 8'h00, rx[23:16])
    $display("startup done");
    foreach (rows[i]) begin
      fault_code = rows[i][55:48];
      tick(3); // read spacing scaled down like the byte gaps
      rd(rows[i][47:24], rows[i][23:0]);
    end
    $display("table done");
    fault_code = 8'h00;
    u_oxs_host_model.frame(1, 24'h010000, rx);
    u_oxs_host_model.frame(3, 24'h81FFFF, rx);
    wr(8'hF6);
    rd(24'h010000, 24'h000CFE);
    rd(24'h000000, 24'h000000);
    wr(8'h01);
    rd(24'h000000, 24'h000100);
    tick(2100);
    rd(24'h000000, 24'h000000);
    `CHK("cal", 16'h1234, active_cal)
    wr(8'h08);
    tick(20);
    `CHK("commit", 16'h1234, commit_data)
    `CHK("strobes", 1, commits)
    rd(24'h000000, 24'h000000);
    wr(8'h01);
    fault_code = 8'h52;
    tick(5);
    fault_code = 8'h00;
    tick(5);
    rd(24'h000000, 24'h002000);
    wr(8'h01);
    cal_error = 1'b1;
    tick(2);
    cal_error = 1'b0;
    rd(24'h000000, 24'h002000);
    $display("calibration done");
    rstn = 1'b0;
    heater_ready = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(3);
    `CHK("reload", 16'h0BAD, active_cal)
    `CHK("reinit", 8'h01, status_code)
    $display("reset done");
    summarize();
  end
endmodule
bind oxs_spi_slave oxs_properties #(.INIT_CYCLES_P(INIT_CYCLES_P)) u_oxs_properties (
  .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .miso(miso),
  .heater_ready(heater_ready), .fault_code(fault_code), .stored_cal(stored_cal),
  .heater_on(heater_on), .status_code(status_code), .active_cal(active_cal),
  .commit_strobe(commit_strobe), .commit_data(commit_data));
